/* hw/txsb_top.sv */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module txsb_top
  import txsb_pkg::*;
#(
  parameter int FRAME_BYTES = txsb_pkg::TXSB_FRAME_BYTES,
  parameter int FRAME_SLOTS = txsb_pkg::TXSB_FRAME_SLOTS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       bp_valid,
  input  wire logic [7:0] bp_data,
  output var  logic       bp_ready,
  output var  logic       tx_valid,
  output var  logic [7:0] tx_data,
  input  wire logic       tx_ready
);
  import txsb_pkg::*;

  localparam int BW = (FRAME_BYTES > 1) ? $clog2(FRAME_BYTES) : 1;
  localparam int SW = (FRAME_SLOTS > 1) ? $clog2(FRAME_SLOTS) : 1;
  localparam int CW = $clog2(FRAME_SLOTS + 1);
  localparam int MW = $clog2(FRAME_BYTES * FRAME_SLOTS);
  localparam logic [BW-1:0] LAST_BYTE = BW'(FRAME_BYTES - 1);
  localparam logic [SW-1:0] LAST_SLOT = SW'(FRAME_SLOTS - 1);
  localparam logic [CW-1:0] FULL_CNT  = CW'(FRAME_SLOTS);

  typedef struct packed {
    logic          en;
    logic          drop;
    logic          replay;
    logic [BW-1:0] wb;
    logic [SW-1:0] ws;
    logic [BW-1:0] rb;
    logic [SW-1:0] rs;
    logic [SW-1:0] rcur;
    logic [CW-1:0] cnt;
    logic [2:0]    flags;
    logic [7:0]    rdata;
    logic          ready;
  } txsb_state_t;

  txsb_state_t q;
  txsb_state_t d;

  logic [7:0]    mem [FRAME_BYTES*FRAME_SLOTS];
  logic          we;
  logic [MW-1:0] waddr;
  logic [MW-1:0] raddr;
  logic          ev_ovf;
  logic          ev_udf;
  logic          fetch;
  logic          sk_in_ready;
  logic          replay_now;
  logic [SW-1:0] slot_now;
  logic          inc;
  logic          dec;
  logic [2:0]    clr;

  function automatic logic [SW-1:0] slot_next(input logic [SW-1:0] s);
    slot_next = (s == LAST_SLOT) ? '0 : SW'(s + 1'b1);
  endfunction

  function automatic logic [SW-1:0] slot_prev(input logic [SW-1:0] s);
    slot_prev = (s == '0) ? LAST_SLOT : SW'(s - 1'b1);
  endfunction

  // ============================================================
  // Next-state logic
  always_comb
  begin
    d      = q;
    ev_ovf = 1'b0;
    ev_udf = 1'b0;
    we     = 1'b0;
    inc    = 1'b0;
    dec    = 1'b0;
    clr    = 3'h0;
    d.ready = 1'b1;
    waddr  = MW'(q.ws * FRAME_BYTES + q.wb);
    fetch  = q.en && sk_in_ready;
    replay_now = (q.rb == '0) ? (q.cnt == '0) : q.replay;
    slot_now   = (q.rb == '0) ? ((q.cnt == '0) ? slot_prev(q.rs) : q.rs) : q.rcur;
    raddr  = MW'(slot_now * FRAME_BYTES + q.rb);

    // Write side
    if (bp_valid && q.en)
    begin
      if (q.wb == '0)
      begin
        d.drop = (q.cnt == FULL_CNT);
        ev_ovf = (q.cnt == FULL_CNT);
      end
      we = (q.wb == '0) ? (q.cnt != FULL_CNT) : !q.drop;
      if (q.wb == LAST_BYTE)
      begin
        d.wb = '0;
        if (we)
        begin
          d.ws = slot_next(q.ws);
          inc  = 1'b1;
        end
      end
      else
        d.wb = BW'(q.wb + 1'b1);
    end

    // Read side
    if (fetch)
    begin
      if (q.rb == '0)
      begin
        ev_udf   = (q.cnt == '0);
        d.replay = (q.cnt == '0);
        d.rcur   = slot_now;
      end
      if (q.rb == LAST_BYTE)
      begin
        d.rb = '0;
        if (!replay_now)
        begin
          d.rs = slot_next(q.rs);
          dec  = 1'b1;
        end
      end
      else
        d.rb = BW'(q.rb + 1'b1);
    end

    d.cnt = CW'(q.cnt + CW'(inc) - CW'(dec));

    // Register access
    d.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        TXSB_ADDR_STATUS: d.rdata = {q.flags, 5'h00};
        TXSB_ADDR_CTRL:   d.rdata = {7'h00, q.en};
        TXSB_ADDR_FILL:   d.rdata = 8'(q.cnt);
        default:          d.rdata = 8'h00;
      endcase
    end
    if (reg_rd && reg_addr == TXSB_ADDR_STATUS)
      clr = 3'h7;
    if (reg_wr && reg_addr == TXSB_ADDR_STATUS)
      clr = reg_wdata[TXSB_BIT_OVF:TXSB_BIT_SLIP];
    if (reg_wr && reg_addr == TXSB_ADDR_CTRL)
      d.en = reg_wdata[TXSB_BIT_EN];

    // Slip flag on drop or replay
    d.flags = (q.flags & ~clr) | {ev_ovf, ev_udf, ev_ovf | ev_udf};

    // Disabled buffer is flushed
    if (!q.en)
    begin
      d.drop   = 1'b0;
      d.replay = 1'b0;
      d.wb     = '0;
      d.ws     = '0;
      d.rb     = '0;
      d.rs     = '0;
      d.rcur   = '0;
      d.cnt    = '0;
    end
  end

  // ============================================================
  // State registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q       <= '0;
      q.en    <= TXSB_EN_RST;
      q.flags <= TXSB_FLAGS_RST;
    end
    else
      q <= d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (we)
      mem[waddr] <= bp_data;
  end

  txsb_skid #(
    .W(8)
  ) u_skid (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .in_valid (fetch),
    .in_data  (mem[raddr]),
    .in_ready (sk_in_ready),
    .out_valid(tx_valid),
    .out_data (tx_data),
    .out_ready(tx_ready)
  );

  assign reg_rdata = q.rdata;
  assign bp_ready  = q.ready;

  // ============================================================
  // Checks
  a_ovf_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev_ovf |=> q.flags[2] && q.drop)
    else $error("overflow flag or drop missing");
  a_drop_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (q.drop && q.wb != '0 && bp_valid) |-> !we)
    else $error("byte of dropped frame written");
  a_udf_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ev_udf |=> q.flags[1] && q.replay && q.cnt == $past(q.cnt) + CW'($past(inc)))
    else $error("underflow flag or replay missing");
  a_slip_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ev_ovf || ev_udf) |=> q.flags[0])
    else $error("slip flag missing");
  a_slip_pairs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(q.flags[0]) |-> (q.flags[2] || q.flags[1]))
    else $error("slip flag without cause");
  a_read_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == TXSB_ADDR_STATUS && !ev_ovf && !ev_udf) |=>
      q.flags == 3'h0 && reg_rdata[7:5] == $past(q.flags))
    else $error("status read did not clear flags");
  a_flags_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!reg_rd && !reg_wr) |=> (q.flags & $past(q.flags)) == $past(q.flags))
    else $error("sticky flag lost");
endmodule
`default_nettype wire

/* hw/txsb_pkg.sv */
`default_nettype none
// ============================================================
// Transmit slip buffer constants
package txsb_pkg;
  // Register byte offsets
  localparam logic [7:0] TXSB_ADDR_STATUS = 8'h00;
  localparam logic [7:0] TXSB_ADDR_CTRL   = 8'h01;
  localparam logic [7:0] TXSB_ADDR_FILL   = 8'h02;
  // Status field positions
  localparam int TXSB_BIT_OVF  = 7;
  localparam int TXSB_BIT_UDF  = 6;
  localparam int TXSB_BIT_SLIP = 5;
  // Control field position and reset values
  localparam int   TXSB_BIT_EN       = 0;
  localparam logic TXSB_EN_RST       = 1'b1;
  localparam logic [2:0] TXSB_FLAGS_RST = 3'h0;
  // Frame geometry defaults
  localparam int TXSB_FRAME_BYTES = 32;
  localparam int TXSB_FRAME_SLOTS = 2;
endpackage
`default_nettype wire

/* hw/txsb_skid.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Two-entry buffer with valid/ready on both sides
module txsb_skid #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready,
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  typedef struct packed {
    logic         v0;
    logic         v1;
    logic [W-1:0] d0;
    logic [W-1:0] d1;
  } txsb_skid_t;

  txsb_skid_t q;
  txsb_skid_t d;

  always_comb
  begin
    d = q;
    if (q.v0 && out_ready)
    begin
      d.v0 = q.v1;
      d.d0 = q.d1;
      d.v1 = 1'b0;
    end
    if (in_valid && !q.v1)
    begin
      if (!d.v0)
      begin
        d.v0 = 1'b1;
        d.d0 = in_data;
      end
      else
      begin
        d.v1 = 1'b1;
        d.d1 = in_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign in_ready  = !q.v1;
  assign out_valid = q.v0;
  assign out_data  = q.d0;
endmodule
`default_nettype wire

/* sim/txsb_bp_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Backplane writer: back-to-back frames on request
module txsb_bp_model #(
  parameter int FB = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       start,
  input  wire logic [3:0] nframes,
  output var  logic       bp_valid,
  output var  logic [7:0] bp_data,
  output var  logic       busy
);
  initial
  begin
    bp_valid = 1'b0;
    bp_data  = 8'h00;
    busy     = 1'b0;
    forever
    begin
      @(posedge sys_clk);
      if (start === 1'b1)
      begin
        busy <= 1'b1;
        for (int k = 0; k < nframes; k++)
          for (int i = 0; i < FB; i++)
          begin
            bp_valid <= 1'b1;
            bp_data  <= 8'(16 * (k + 1) + i);
            @(posedge sys_clk);
          end
        bp_valid <= 1'b0;
        busy     <= 1'b0;
      end
      // Idle line keeps toggling
      bp_data <= ~bp_data;
    end
  end
endmodule
`default_nettype wire

/* sim/tb_txsb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Slip buffer status bench
module tb_txsb_top;
  import txsb_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} txsb_row_t;
  logic       sys_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       bp_valid;
  logic [7:0] bp_data;
  logic       bp_ready;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready = 1'b1;
  logic       start = 1'b0;
  logic       busy;
  logic [7:0] q[$];
  logic [7:0] v;
  int         err_count = 0;
  int         checks = 0;
  txsb_row_t  rows [6] = '{
    '{1'b0, TXSB_ADDR_CTRL, 8'h00, 8'h01}, '{1'b1, TXSB_ADDR_CTRL, 8'h00, 8'h00},
    '{1'b0, TXSB_ADDR_FILL, 8'h00, 8'h00}, '{1'b1, TXSB_ADDR_STATUS, 8'he0, 8'h00},
    '{1'b0, TXSB_ADDR_STATUS, 8'h00, 8'h00}, '{1'b0, 8'h03, 8'h00, 8'h00}};

  txsb_top #(.FRAME_BYTES(4), .FRAME_SLOTS(2)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bp_valid(bp_valid), .bp_data(bp_data), .bp_ready(bp_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  txsb_bp_model #(.FB(4)) u_bp (.sys_clk(sys_clk), .start(start), .nframes(4'h3),
    .bp_valid(bp_valid), .bp_data(bp_data), .busy(busy));

  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      q.push_back(tx_data);
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic close_out;
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #300000;
    err_count++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[r])
    begin
      if (rows[r].wr)
        reg_write(rows[r].a, rows[r].d);
      else
      begin
        reg_read(rows[r].a, v);
        check(v, rows[r].e);
      end
    end
    // Overflow while the framer stalls
    tx_ready <= 1'b0;
    repeat (2) @(posedge sys_clk);
    q.delete();
    reg_write(TXSB_ADDR_CTRL, 8'h01);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge sys_clk);
    check({7'h00, busy}, 8'h00);
    check({7'h00, bp_ready}, 8'h01);
    repeat (3) @(posedge sys_clk);
    reg_read(TXSB_ADDR_STATUS, v);
    check(v, 8'he0);
    reg_read(TXSB_ADDR_FILL, v);
    check(v, 8'h02);
    reg_read(TXSB_ADDR_STATUS, v);
    check(v, 8'h00);
    // Drain: replay, frame 1, frame 2, then replay of frame 2
    tx_ready <= 1'b1;
    for (int n = 0; n < 200 && q.size() < 16; n++) @(posedge sys_clk);
    tx_ready <= 1'b0;
    check({7'h00, q.size() >= 16}, 8'h01);
    for (int i = 0; i < 12; i++)
      check((q.size() > 4 + i) ? q[4 + i] : 8'h00, 8'(16 * (i < 4 ? 1 : 2) + i % 4));
    reg_read(TXSB_ADDR_STATUS, v);
    check(v, 8'h60);
    // Mid-run reset, status read taken at first edge after release
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({tx_valid, bp_ready, 6'h00}, 8'h00);
    check(reg_rdata, 8'h00);
    rst_n    <= 1'b1;
    reg_rd   <= 1'b1;
    reg_addr <= TXSB_ADDR_STATUS;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    check(v, 8'h00);
    check({7'h00, bp_ready}, 8'h01);
    // Replay event in the clearing cycle wins
    reg_read(TXSB_ADDR_STATUS, v);
    check(v, 8'h60);
    reg_read(TXSB_ADDR_STATUS, v);
    check(v, 8'h00);
    reg_read(TXSB_ADDR_CTRL, v);
    check(v, 8'h01);
    reg_read(TXSB_ADDR_FILL, v);
    check(v, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
